// ===== src/afesc_pkg.sv
package afesc_pkg;

    // ----------------------------------------------------------------
    // Register map, byte addresses on the Wishbone bus.
    // ----------------------------------------------------------------
    localparam logic [7:0] AFESC_CTRL_ADDR = 8'h00; // Mode, clamp and reference control.
    localparam logic [7:0] AFESC_RED_ADDR = 8'h04; // Red offset and gain codes.
    localparam logic [7:0] AFESC_GREEN_ADDR = 8'h08; // Green offset and gain codes.
    localparam logic [7:0] AFESC_BLUE_ADDR = 8'h0C; // Blue offset and gain codes.
    localparam logic [7:0] AFESC_MONO_ADDR = 8'h10; // Monochrome offset and gain codes.
    localparam logic [7:0] AFESC_STATUS_ADDR = 8'h14; // Applied codes and clamp state.
    localparam logic [7:0] AFESC_SAMPLE_ADDR = 8'h18; // Last converted sample word.

    // ----------------------------------------------------------------
    // Control register fields.
    // ----------------------------------------------------------------
    localparam int AFESC_MONO_BIT = 0; // Monochrome operation.
    localparam int AFESC_SEL_LSB = 1; // Colour code select, two bits.
    localparam int AFESC_CLAMP_BIT = 3; // Clamp enable.
    localparam int AFESC_POS_LSB = 4; // Reset sample position, two bits.
    localparam int AFESC_DS_BIT = 6; // Double sampling enable.
    localparam int AFESC_RANGE_BIT = 7; // Reference DAC range.
    localparam int AFESC_EXTREF_BIT = 8; // External reference select.
    localparam int AFESC_REFCODE_LSB = 9; // Reference level code, four bits.
    localparam logic [12:0] AFESC_CTRL_RESET = 13'h0040; // Double sampling on at reset.

    // Code registers: offset in the low byte, gain in the next byte.
    localparam int AFESC_OFFSET_LSB = 0;
    localparam int AFESC_GAIN_LSB = 8;
    localparam logic [7:0] AFESC_CODE_RESET = 8'h00;

    // Colour select encodings; the fourth value is reserved.
    localparam logic [1:0] AFESC_SEL_RED = 2'h0;
    localparam logic [1:0] AFESC_SEL_GREEN = 2'h1;
    localparam logic [1:0] AFESC_SEL_BLUE = 2'h2;

    // ----------------------------------------------------------------
    // Pixel timing, in master clock cycles after the strobe edge.
    // ----------------------------------------------------------------
    localparam logic [2:0] AFESC_PIX_START = 3'h1; // Count value after the edge.
    localparam logic [2:0] AFESC_PIX_END = 3'h7; // Count stops here.
    localparam logic [2:0] AFESC_RESET_BASE = 3'h2; // Reset sample at position zero.

    // Output word layout.
    localparam int AFESC_WORD_W = 16;
    localparam int AFESC_NIB_W = 4;
    localparam logic [1:0] AFESC_NIB_LAST = 2'h3; // Four nibbles per word.

endpackage

// ===== src/afesc_nibble_out.sv
`timescale 1ns/1ps
`default_nettype none

module afesc_nibble_out (
    input wire logic clk,
    input wire logic srst,
    input wire logic load,
    input wire logic [afesc_pkg::AFESC_WORD_W-1:0] word,
    output logic [afesc_pkg::AFESC_NIB_W-1:0] nibble,
    output logic nibbleValid,
    output logic nibbleFirst
);
    import afesc_pkg::*;

    // Word being shifted out and the nibble index within it.
    logic [AFESC_WORD_W-1:0] shiftWord;
    logic [1:0] nibIdx;
    logic busy;

    // ----------------------------------------------------------------
    // Shifter.
    // ----------------------------------------------------------------
    // A new load restarts the word, most significant nibble first; a
    // word that arrives faster than four cycles cuts the old one short.
    always_ff @(posedge clk) begin
        if (srst) begin
            shiftWord <= '0;
            nibIdx <= 2'h0;
            busy <= 1'b0;
            nibble <= '0;
            nibbleValid <= 1'b0;
            nibbleFirst <= 1'b0;
        end else if (load) begin
            shiftWord <= {word[AFESC_WORD_W-AFESC_NIB_W-1:0], {AFESC_NIB_W{1'b0}}};
            nibble <= word[AFESC_WORD_W-1 -: AFESC_NIB_W];
            nibIdx <= 2'h0;
            busy <= 1'b1;
            nibbleValid <= 1'b1;
            nibbleFirst <= 1'b1;
        end else if (busy && nibIdx != AFESC_NIB_LAST) begin
            // Remaining nibbles follow on consecutive cycles.
            nibble <= shiftWord[AFESC_WORD_W-1 -: AFESC_NIB_W];
            shiftWord <= {shiftWord[AFESC_WORD_W-AFESC_NIB_W-1:0], {AFESC_NIB_W{1'b0}}};
            nibIdx <= nibIdx + 2'h1;
            nibbleValid <= 1'b1;
            nibbleFirst <= 1'b0;
        end else begin
            busy <= 1'b0;
            nibbleValid <= 1'b0;
            nibbleFirst <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks.
    // ----------------------------------------------------------------
    // The most significant nibble follows a load by one cycle.
    nibble_first_a: assert property (
        @(posedge clk) disable iff (srst)
        load |=> nibbleFirst && nibbleValid
            && nibble == $past(word[AFESC_WORD_W-1 -: AFESC_NIB_W]))
        else $error("First nibble wrong.");

    // An uncut word ends with its least significant nibble four cycles on.
    nibble_order_a: assert property (
        @(posedge clk) disable iff (srst)
        load ##1 !load[*3] |=> nibbleValid && !nibbleFirst
            && nibble == $past(word[AFESC_NIB_W-1:0], 4))
        else $error("Nibble order broken.");

endmodule

`default_nettype wire

// ===== src/afe_sampling_control.sv
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module afesc_sampling_control (
    input wire logic clk,
    input wire logic srst,
    // Wishbone classic slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Sample strobe pin, asynchronous to the master clock.
    input wire logic sampleStrobe,
    // Converter result, same clock domain.
    input wire logic [afesc_pkg::AFESC_WORD_W-1:0] adcWord,
    input wire logic adcValid,
    // Analogue channel controls.
    output logic [7:0] offsetCode,
    output logic [7:0] gainCode,
    output logic clampPulse,
    output logic clampSwitch,
    output logic videoSampleClk,
    output logic resetSampleClk,
    output logic refSelectReset,
    output logic [3:0] refLevelCode,
    output logic refDacRange,
    output logic refDacEnable,
    // Output data bus.
    output logic [afesc_pkg::AFESC_NIB_W-1:0] dataNibble,
    output logic dataValid,
    output logic dataFirst
);
    import afesc_pkg::*;

    // ----------------------------------------------------------------
    // Host registers.
    // ----------------------------------------------------------------
    logic [12:0] ctrlReg; // Control fields.
    logic [15:0] redReg; // Red gain and offset.
    logic [15:0] greenReg; // Green gain and offset.
    logic [15:0] blueReg; // Blue gain and offset.
    logic [15:0] monoReg; // Monochrome gain and offset.
    logic [AFESC_WORD_W-1:0] lastSample; // Last converted word.
    logic clampArmed; // Clamp enable captured for this pixel.
    logic busReq; // A bus cycle waits for its answer.
    logic busWrite; // The master sees ack on a write at this edge.

    assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

    // Writes land on the edge at which the master sees ack, so a request
    // dropped before its answer changes nothing; ack lasts one cycle, so a
    // held request is written again every second cycle. Byte lanes 0 and 1 carry all fields.
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrlReg <= AFESC_CTRL_RESET;
            redReg <= {AFESC_CODE_RESET, AFESC_CODE_RESET};
            greenReg <= {AFESC_CODE_RESET, AFESC_CODE_RESET};
            blueReg <= {AFESC_CODE_RESET, AFESC_CODE_RESET};
            monoReg <= {AFESC_CODE_RESET, AFESC_CODE_RESET};
        end else if (busWrite) begin
            case (wb_adr_i)
                AFESC_CTRL_ADDR: begin
                    if (wb_sel_i[0]) ctrlReg[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) ctrlReg[12:8] <= wb_dat_i[12:8];
                end
                AFESC_RED_ADDR: begin
                    if (wb_sel_i[0]) redReg[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) redReg[15:8] <= wb_dat_i[15:8];
                end
                AFESC_GREEN_ADDR: begin
                    if (wb_sel_i[0]) greenReg[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) greenReg[15:8] <= wb_dat_i[15:8];
                end
                AFESC_BLUE_ADDR: begin
                    if (wb_sel_i[0]) blueReg[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) blueReg[15:8] <= wb_dat_i[15:8];
                end
                AFESC_MONO_ADDR: begin
                    if (wb_sel_i[0]) monoReg[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) monoReg[15:8] <= wb_dat_i[15:8];
                end
                default: begin
                    // Read-only and unmapped words ignore writes.
                end
            endcase
        end
    end

    // Bus answer: one-cycle ack for every address, zeros where unmapped.
    always_ff @(posedge clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= busReq;
            case (wb_adr_i)
                AFESC_CTRL_ADDR: wb_dat_o <= {19'h00000, ctrlReg};
                AFESC_RED_ADDR: wb_dat_o <= {16'h0000, redReg};
                AFESC_GREEN_ADDR: wb_dat_o <= {16'h0000, greenReg};
                AFESC_BLUE_ADDR: wb_dat_o <= {16'h0000, blueReg};
                AFESC_MONO_ADDR: wb_dat_o <= {16'h0000, monoReg};
                AFESC_STATUS_ADDR: wb_dat_o <= {15'h0000, clampArmed, gainCode, offsetCode};
                AFESC_SAMPLE_ADDR: wb_dat_o <= {16'h0000, lastSample};
                default: wb_dat_o <= '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Configuration stage.
    // ----------------------------------------------------------------
    // The sampling logic reads only these copies, so a field written in
    // mid-pixel changes between cycles as a whole word, never in parts.
    logic cfgMono;
    logic [1:0] cfgSel;
    logic cfgClamp;
    logic [1:0] cfgPos;
    logic cfgDs;
    logic cfgRange;
    logic cfgExtRef;
    logic [3:0] cfgRefCode;

    always_ff @(posedge clk) begin
        if (srst) begin
            cfgMono <= AFESC_CTRL_RESET[AFESC_MONO_BIT];
            cfgSel <= AFESC_CTRL_RESET[AFESC_SEL_LSB +: 2];
            cfgClamp <= AFESC_CTRL_RESET[AFESC_CLAMP_BIT];
            cfgPos <= AFESC_CTRL_RESET[AFESC_POS_LSB +: 2];
            cfgDs <= AFESC_CTRL_RESET[AFESC_DS_BIT];
            cfgRange <= AFESC_CTRL_RESET[AFESC_RANGE_BIT];
            cfgExtRef <= AFESC_CTRL_RESET[AFESC_EXTREF_BIT];
            cfgRefCode <= AFESC_CTRL_RESET[AFESC_REFCODE_LSB +: 4];
        end else begin
            cfgMono <= ctrlReg[AFESC_MONO_BIT];
            cfgSel <= ctrlReg[AFESC_SEL_LSB +: 2];
            cfgClamp <= ctrlReg[AFESC_CLAMP_BIT];
            cfgPos <= ctrlReg[AFESC_POS_LSB +: 2];
            cfgDs <= ctrlReg[AFESC_DS_BIT];
            cfgRange <= ctrlReg[AFESC_RANGE_BIT];
            cfgExtRef <= ctrlReg[AFESC_EXTREF_BIT];
            cfgRefCode <= ctrlReg[AFESC_REFCODE_LSB +: 4];
        end
    end

    // ----------------------------------------------------------------
    // Code selection.
    // ----------------------------------------------------------------
    // The reserved select value keeps the codes already applied, which
    // is harmless but software should not lean on it.
    always_ff @(posedge clk) begin
        if (srst) begin
            offsetCode <= AFESC_CODE_RESET;
            gainCode <= AFESC_CODE_RESET;
        end else if (cfgMono) begin
            offsetCode <= monoReg[AFESC_OFFSET_LSB +: 8];
            gainCode <= monoReg[AFESC_GAIN_LSB +: 8];
        end else begin
            case (cfgSel)
                AFESC_SEL_RED: begin
                    offsetCode <= redReg[AFESC_OFFSET_LSB +: 8];
                    gainCode <= redReg[AFESC_GAIN_LSB +: 8];
                end
                AFESC_SEL_GREEN: begin
                    offsetCode <= greenReg[AFESC_OFFSET_LSB +: 8];
                    gainCode <= greenReg[AFESC_GAIN_LSB +: 8];
                end
                AFESC_SEL_BLUE: begin
                    offsetCode <= blueReg[AFESC_OFFSET_LSB +: 8];
                    gainCode <= blueReg[AFESC_GAIN_LSB +: 8];
                end
                default: begin
                    // Reserved encoding: hold the present codes.
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Strobe synchroniser and pixel timing.
    // ----------------------------------------------------------------
    logic strobeMeta; // First stage, read only by the second.
    logic strobeSync;
    logic strobeLast;
    logic strobeEdge; // First master clock edge inside a strobe pulse.
    logic [2:0] pixCount; // Cycles since that edge, zero until the first strobe, then parked at 7.
    logic resetHit; // Reset level instant of this pixel.

    always_ff @(posedge clk) begin
        if (srst) begin
            strobeMeta <= 1'b0;
            strobeSync <= 1'b0;
            strobeLast <= 1'b0;
        end else begin
            strobeMeta <= sampleStrobe;
            strobeSync <= strobeMeta;
            strobeLast <= strobeSync;
        end
    end

    assign strobeEdge = strobeSync && !strobeLast;
    assign resetHit = (pixCount == AFESC_RESET_BASE + {1'b0, cfgPos});

    // The count saturates so a slow strobe leaves it parked at the end.
    always_ff @(posedge clk) begin
        if (srst) begin
            pixCount <= 3'h0;
        end else if (strobeEdge) begin
            pixCount <= AFESC_PIX_START;
        end else if (pixCount != 3'h0 && pixCount != AFESC_PIX_END) begin
            pixCount <= pixCount + 3'h1;
        end
    end

    // Clamp enable is sampled once per strobe and alone decides the clamp.
    always_ff @(posedge clk) begin
        if (srst) begin
            clampArmed <= 1'b0;
        end else if (strobeEdge) begin
            clampArmed <= cfgClamp;
        end
    end

    // Sampling clocks, clamp pulse and switch. Clamp does not depend on
    // the double sampling mode, so both modes can clamp.
    always_ff @(posedge clk) begin
        if (srst) begin
            clampPulse <= 1'b0;
            clampSwitch <= 1'b0;
            videoSampleClk <= 1'b0;
            resetSampleClk <= 1'b0;
        end else begin
            clampPulse <= resetHit && clampArmed;
            clampSwitch <= resetHit && clampArmed;
            videoSampleClk <= strobeEdge;
            // Without double sampling the reference pin is sampled together
            // with the video level instead of at the reset instant.
            resetSampleClk <= cfgDs ? resetHit : strobeEdge;
        end
    end

    // ----------------------------------------------------------------
    // Reference generation.
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            refSelectReset <= AFESC_CTRL_RESET[AFESC_DS_BIT];
            refLevelCode <= AFESC_CTRL_RESET[AFESC_REFCODE_LSB +: 4];
            refDacRange <= AFESC_CTRL_RESET[AFESC_RANGE_BIT];
            refDacEnable <= !AFESC_CTRL_RESET[AFESC_EXTREF_BIT];
        end else begin
            refSelectReset <= cfgDs;
            refLevelCode <= cfgRefCode;
            refDacRange <= cfgRange;
            refDacEnable <= !cfgExtRef;
        end
    end

    // ----------------------------------------------------------------
    // Output data.
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            lastSample <= '0;
        end else if (adcValid) begin
            lastSample <= adcWord;
        end
    end

    afesc_nibble_out afesc_nibble_out_inst (
        .clk(clk),
        .srst(srst),
        .load(adcValid),
        .word(adcWord),
        .nibble(dataNibble),
        .nibbleValid(dataValid),
        .nibbleFirst(dataFirst)
    );

    // ----------------------------------------------------------------
    // Checks.
    // ----------------------------------------------------------------
    mono_codes_a: assert property (
        @(posedge clk) disable iff (srst)
        $past(cfgMono) |-> offsetCode == $past(monoReg[7:0]) && gainCode == $past(monoReg[15:8]))
        else $error("Mono codes not applied.");

    green_codes_a: assert property (
        @(posedge clk) disable iff (srst)
        !$past(cfgMono) && $past(cfgSel) == 2'h1 |-> gainCode == $past(greenReg[15:8]))
        else $error("Green gain not applied.");

    reserved_hold_a: assert property (
        @(posedge clk) disable iff (srst)
        !$past(cfgMono) && $past(cfgSel) == 2'h3 |-> $stable(offsetCode) && $stable(gainCode))
        else $error("Reserved select changed codes.");

    clamp_capture_a: assert property (
        @(posedge clk) disable iff (srst)
        strobeEdge |=> clampArmed == $past(cfgClamp))
        else $error("Clamp enable not captured.");

    clamp_gate_a: assert property (
        @(posedge clk) disable iff (srst)
        clampPulse |-> $past(clampArmed) && $past(pixCount) == 3'h2 + {1'b0, $past(cfgPos)})
        else $error("Clamp pulse without cause.");

    clamp_switch_a: assert property (
        @(posedge clk) disable iff (srst)
        clampSwitch == clampPulse)
        else $error("Clamp switch differs from pulse.");

    nonds_sample_a: assert property (
        @(posedge clk) disable iff (srst)
        strobeEdge && !cfgDs |=> resetSampleClk && videoSampleClk)
        else $error("Reference not sampled with video.");

    ext_ref_a: assert property (
        @(posedge clk) disable iff (srst)
        ctrlReg[AFESC_EXTREF_BIT] ##2 1'b1 |-> !refDacEnable)
        else $error("Internal DAC on with external reference.");

endmodule

`default_nettype wire

// ===== tb/afesc_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Sensor side: sample strobe pin and converter words.
// ------------------------------------------------------------
module afesc_sensor_model (
    input wire logic clk,
    input wire logic fire,
    input wire logic conv,
    input wire logic [15:0] convWord,
    output logic sampleStrobe,
    output logic [15:0] adcWord,
    output logic adcValid
);
    logic [1:0] hold = 2'h0; // Strobe cycles still to come.

    // A request gives a three-cycle strobe, wide enough for the synchroniser.
    always @(posedge clk) begin
        hold <= fire ? 2'h2 : (hold != 2'h0 ? hold - 2'h1 : 2'h0);
        sampleStrobe <= fire || hold != 2'h0;
    end

    // Between words the bus shows the inverted word, so stale data never matches.
    always @(posedge clk) begin
        adcValid <= conv;
        adcWord <= conv ? convWord : ~convWord;
    end
endmodule

`default_nettype wire

// ===== tb/afesc_sampling_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module afesc_sampling_control_tb;
    import afesc_pkg::*;

    // ------------------------------------------------------------
    // Stimulus and observed nets.
    // ------------------------------------------------------------
    logic clk, srst, cyc, stb, we, ack, fire, conv, strobe, adcValid;
    logic [7:0] adr, offsetCode, gainCode;
    logic [3:0] sel, refLevelCode, dataNibble;
    logic [31:0] wdat, rdat;
    logic [15:0] convWord, adcWord;
    logic clampPulse, clampSwitch, vsc, rsc, refSel, range, dacEn, dataValid, dataFirst;
    int n_errors = 0; // Mismatches seen.
    int checks = 0; // Comparisons made.

    afesc_sensor_model afesc_sensor_model_inst (.clk(clk), .fire(fire), .conv(conv),
        .convWord(convWord), .sampleStrobe(strobe), .adcWord(adcWord), .adcValid(adcValid));

    afesc_sampling_control afesc_sampling_control_inst (.clk(clk), .srst(srst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sampleStrobe(strobe),
        .adcWord(adcWord), .adcValid(adcValid), .offsetCode(offsetCode),
        .gainCode(gainCode), .clampPulse(clampPulse), .clampSwitch(clampSwitch),
        .videoSampleClk(vsc), .resetSampleClk(rsc), .refSelectReset(refSel),
        .refLevelCode(refLevelCode), .refDacRange(range), .refDacEnable(dacEn),
        .dataNibble(dataNibble), .dataValid(dataValid), .dataFirst(dataFirst));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------
    // One value compare; values taken at an edge are the settled pre-edge ones.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic tally_and_finish;
        if (n_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Classic single cycle; held until ack is seen, then released for a cycle.
    task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (n >= 50) chk("bus ack", 32'h1, 32'h0);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    // Levels straight after reset, and the control word's default.
    task automatic t_reset;
        logic [31:0] q;
        chk("refSel", 32'h1, refSel);
        chk("dacEn", 32'h1, dacEn);
        chk("clamp", 32'h0, clampPulse);
        wbx(1'b0, AFESC_CTRL_ADDR, 32'h0, q);
        chk("ctrl", 32'h40, q);
    endtask

    // Code sets per colour, reserved select, monochrome and bus corners.
    task automatic t_colour;
        logic [31:0] q;
        int k;
        for (int i = 0; i < 4; i++) wbx(1'b1, 8'(4 + 4 * i), 32'(16'h9010 + 16'h0101 * i), q);
        wbx(1'b0, AFESC_RED_ADDR, 32'h0, q);
        chk("red reg", 32'h9010, q);
        for (int s = 0; s < 5; s++) begin
            k = (s == 3) ? 2 : (s == 4 ? 3 : s);
            wbx(1'b1, AFESC_CTRL_ADDR, 32'h40 | (s == 4 ? 32'h5 : 32'(s) << 1), q);
            repeat (4) @(posedge clk);
            chk("offset", 32'(8'h10 + k), offsetCode);
            chk("gain", 32'(8'h90 + k), gainCode);
        end
        wbx(1'b1, AFESC_STATUS_ADDR, 32'h0, q);
        wbx(1'b0, AFESC_STATUS_ADDR, 32'h0, q);
        chk("status", 32'h9313, q[15:0]);
        wbx(1'b0, 8'h1C, 32'h0, q);
        chk("unmapped", 32'h0, q);
    endtask

    // Reference DAC controls follow the control word.
    task automatic t_ref(input logic r, input logic x, input logic [3:0] c);
        logic [31:0] q;
        wbx(1'b1, AFESC_CTRL_ADDR, 32'h40 | 32'(r) << 7 | 32'(x) << 8 | 32'(c) << 9, q);
        repeat (4) @(posedge clk);
        chk("refCode", 32'(c), refLevelCode);
        chk("range", 32'(r), range);
        chk("dacEn", 32'(!x), dacEn);
    endtask

    // Pulse positions after a strobe, relative to the video sample.
    task automatic t_clamp(input logic [1:0] p, input logic en, input logic ds);
        logic [31:0] q;
        int v, c, s, r;
        v = -1;
        c = -1;
        s = -1;
        r = -1;
        wbx(1'b1, AFESC_CTRL_ADDR, 32'(ds) << 6 | 32'(p) << 4 | 32'(en) << 3, q);
        repeat (3) @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            if (vsc === 1'b1) v = i;
            if (clampPulse === 1'b1) c = i;
            if (clampSwitch === 1'b1) s = i;
            if (rsc === 1'b1) r = i;
        end
        chk("video", 32'h1, 32'(v >= 0));
        chk("clamp at", en ? 32'(v + 2 + p) : 32'hFFFFFFFF, 32'(c));
        chk("switch at", 32'(c), 32'(s));
        chk("rsample at", ds ? 32'(v + 2 + p) : 32'(v), 32'(r));
        chk("refSel", 32'(ds), refSel);
        wbx(1'b0, AFESC_STATUS_ADDR, 32'h0, q);
        chk("armed", 32'(en), 32'(q[16]));
    endtask

    // A word leaves as four nibbles, most significant first.
    task automatic t_data(input logic [15:0] w);
        logic [31:0] q;
        int n;
        n = 0;
        convWord <= w;
        conv <= 1'b1;
        @(posedge clk);
        conv <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (dataFirst !== 1'b1 && n < 10);
        for (int k = 0; k < 4; k++) begin
            if (k > 0) @(posedge clk);
            chk("nibble", 32'(w[15 - 4 * k -: 4]), dataNibble);
            chk("valid", 32'h1, dataValid);
            chk("first", 32'(k == 0), dataFirst);
        end
        wbx(1'b0, AFESC_SAMPLE_ADDR, 32'h0, q);
        chk("sample", 32'(w), q);
    endtask

    initial begin
        {srst, cyc, stb, we, fire, conv} = 6'b100000;
        {adr, sel, wdat, convWord} = '0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_colour();
        t_ref(1'b1, 1'b1, 4'hA);
        t_ref(1'b0, 1'b0, 4'h5);
        for (int p = 0; p < 4; p++) t_clamp(2'(p), 1'b1, 1'b1);
        t_clamp(2'h2, 1'b0, 1'b1);
        t_clamp(2'h1, 1'b1, 1'b0);
        t_data(16'hA5C3);
        t_data(16'h3C5A);
        tally_and_finish();
    end

    // Cuts a hang short; the whole run needs well under this.
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
